// file: sbs_pkg.sv
// Constants and types shared by the burst SRAM control block
package sbs_pkg;
    localparam int         SBS_ADDR_W      = 17;
    localparam int         SBS_LANES       = 4;
    localparam int         SBS_LANE_W      = 9;
    localparam int         SBS_BURST_W     = 2;
    localparam int         SBS_FIFO_DEPTH  = 32;
    localparam logic [1:0] SBS_BURST_FIRST = 2'h0;
    localparam logic [1:0] SBS_BURST_STEP  = 2'h1;
    localparam logic       SBS_ORDER_INTLV = 1'h1;

    typedef enum logic [1:0] {
        SBS_ST_DESEL = 2'b00,
        SBS_ST_READ  = 2'b01,
        SBS_ST_WRITE = 2'b10
    } sbs_state_t;
endpackage

// file: sbs_fifo.sv
// Write-posting FIFO with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
module sbs_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32
) (
    input  wire logic             clk_in,
    input  wire logic             rst_in,
    input  wire logic             in_valid_in,
    output logic                  in_ready_out,
    input  wire logic [WIDTH-1:0] in_data_in,
    output logic                  out_valid_out,
    input  wire logic             out_ready_in,
    output logic      [WIDTH-1:0] out_data_out
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [AW:0] FULL_COUNT = (AW + 1)'(DEPTH);

    logic [WIDTH-1:0] store [0:DEPTH-1];
    logic [AW-1:0]    wr_idx;
    logic [AW-1:0]    rd_idx;
    logic [AW:0]      count;
    logic             full;
    logic             empty;
    wire logic        push;
    wire logic        pop;
    wire logic [AW:0] next_count;

    // Wraps cleanly for depths that are not a power of two
    function automatic logic [AW-1:0] step_idx(input logic [AW-1:0] idx);
        step_idx = (idx == AW'(DEPTH - 1)) ? '0 : AW'(idx + 1'b1);
    endfunction

    assign push          = in_valid_in & ~full;
    assign pop           = out_ready_in & ~empty;
    assign next_count    = (AW + 1)'(count + {{AW{1'b0}}, push}
                                            - {{AW{1'b0}}, pop});
    assign in_ready_out  = ~full;
    assign out_valid_out = ~empty;
    assign out_data_out  = store[rd_idx];

    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            wr_idx <= '0;
            rd_idx <= '0;
            count  <= '0;
            full   <= 1'b0;
            empty  <= 1'b1;
        end
        else
        begin
            if (push)
                wr_idx <= step_idx(wr_idx);
            if (pop)
                rd_idx <= step_idx(rd_idx);
            count <= next_count;
            full  <= (next_count == FULL_COUNT);
            empty <= (next_count == '0);
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (push)
            store[wr_idx] <= in_data_in;
    end
endmodule // sbs_fifo
`default_nettype wire

// file: sbs_control.sv
// Burst SRAM control: select decode, burst counter, writes, output drive
`timescale 1ns/1ps
`default_nettype none
module sbs_control #(
    parameter int ADDR_W     = sbs_pkg::SBS_ADDR_W,
    parameter int LANES      = sbs_pkg::SBS_LANES,
    parameter int LANE_W     = sbs_pkg::SBS_LANE_W,
    parameter int FIFO_DEPTH = sbs_pkg::SBS_FIFO_DEPTH
) (
    input  wire logic                    SYS_CLK_IN,
    input  wire logic                    RST_IN,
    input  wire logic                    CHIP_ENABLE_PRIMARY_N_IN,
    input  wire logic                    CHIP_ENABLE_EXPAND_HI_IN,
    input  wire logic                    CHIP_ENABLE_EXPAND_N_IN,
    input  wire logic                    ADDR_STROBE_PROCESSOR_N_IN,
    input  wire logic                    ADDR_STROBE_CONTROLLER_N_IN,
    input  wire logic                    BURST_ADVANCE_N_IN,
    input  wire logic                    BURST_ORDER_SELECT_IN,
    input  wire logic                    GLOBAL_WRITE_N_IN,
    input  wire logic                    WRITE_ENABLE_N_IN,
    input  wire logic [LANES-1:0]        BYTE_WRITE_SEL_N_IN,
    input  wire logic [ADDR_W-1:0]       ADDR_IN,
    input  wire logic                    OUTPUT_ENABLE_N_IN,
    input  wire logic [LANES*LANE_W-1:0] DATA_LANE_IO_IN,
    output logic      [LANES*LANE_W-1:0] DATA_LANE_IO_OUT,
    output logic                         DATA_LANE_IO_OE_N_OUT,
    output logic                         WRITE_READY_OUT
);
    localparam int DW    = LANES * LANE_W;
    localparam int FW    = ADDR_W + DW + LANES;
    localparam int WORDS = 1 << ADDR_W;
    localparam int BW    = sbs_pkg::SBS_BURST_W;

    sbs_pkg::sbs_state_t state;
    sbs_pkg::sbs_state_t next_state;
    logic [ADDR_W-BW-1:0] base_hi;
    logic [BW-1:0]        start_low;
    logic [BW-1:0]        cnt;
    logic                 drive;
    logic [DW-1:0]        dout;
    logic [DW-1:0]        mem [0:WORDS-1];

    wire logic              proc_strobe;
    wire logic              new_cycle;
    wire logic              enables_ok;
    wire logic              deselect;
    wire logic              begin_cycle;
    wire logic              cont_cycle;
    wire logic              wr_decode;
    wire logic [LANES-1:0]  wr_mask;
    wire logic              beat_write;
    wire logic              beat_read;
    wire logic [BW-1:0]     next_cnt;
    wire logic [BW-1:0]     cur_low;
    wire logic [ADDR_W-1:0] acc_addr;
    wire logic              fifo_ready;
    wire logic              drain_valid;
    wire logic              drain_ready;
    wire logic [FW-1:0]     drain_data;
    wire logic [ADDR_W-1:0] drain_addr;
    wire logic [DW-1:0]     drain_word;
    wire logic [LANES-1:0]  drain_mask;

    // Burst low address for a given beat and order
    function automatic logic [BW-1:0] burst_low(
        input logic [BW-1:0] start,
        input logic [BW-1:0] beat,
        input logic          order
    );
        burst_low = (order == sbs_pkg::SBS_ORDER_INTLV)
                  ? (start ^ beat)
                  : BW'(start + beat);
    endfunction

    // Processor strobe only counts with primary enable low
    assign proc_strobe = ~ADDR_STROBE_PROCESSOR_N_IN
                       & ~CHIP_ENABLE_PRIMARY_N_IN;
    assign new_cycle   = proc_strobe | ~ADDR_STROBE_CONTROLLER_N_IN;
    assign enables_ok  = ~CHIP_ENABLE_PRIMARY_N_IN
                       & CHIP_ENABLE_EXPAND_HI_IN
                       & ~CHIP_ENABLE_EXPAND_N_IN;
    assign deselect    = new_cycle & ~enables_ok;
    assign begin_cycle = new_cycle & enables_ok;
    assign cont_cycle  = ~new_cycle
                       & (state != sbs_pkg::SBS_ST_DESEL);

    assign wr_decode = ~GLOBAL_WRITE_N_IN
                     | (~WRITE_ENABLE_N_IN
                        & ~(&BYTE_WRITE_SEL_N_IN));
    assign wr_mask   = ~GLOBAL_WRITE_N_IN ? {LANES{1'b1}}
                                          : ~BYTE_WRITE_SEL_N_IN;

    // Processor-started beats are reads whatever the write pins say
    assign beat_write = begin_cycle ? (~proc_strobe & wr_decode)
                                    : (cont_cycle & wr_decode);
    assign beat_read  = (begin_cycle | cont_cycle) & ~beat_write;

    assign next_cnt = (cont_cycle & ~BURST_ADVANCE_N_IN)
                    ? BW'(cnt + sbs_pkg::SBS_BURST_STEP)
                    : cnt;
    assign cur_low  = burst_low(start_low, next_cnt,
                                BURST_ORDER_SELECT_IN);
    assign acc_addr = begin_cycle ? ADDR_IN : {base_hi, cur_low};

    assign next_state = deselect    ? sbs_pkg::SBS_ST_DESEL
                      : beat_write  ? sbs_pkg::SBS_ST_WRITE
                      : beat_read   ? sbs_pkg::SBS_ST_READ
                      : state;

    // Single-port array: a read beat owns it, so posted writes wait
    assign drain_ready = ~beat_read;
    assign drain_addr  = drain_data[FW-1 -: ADDR_W];
    assign drain_word  = drain_data[LANES +: DW];
    assign drain_mask  = drain_data[LANES-1:0];

    // Output enable is combined without a clock so it acts at once
    assign DATA_LANE_IO_OE_N_OUT = OUTPUT_ENABLE_N_IN | ~drive;
    assign DATA_LANE_IO_OUT      = dout;
    assign WRITE_READY_OUT       = fifo_ready;

    sbs_fifo #(
        .WIDTH (FW),
        .DEPTH (FIFO_DEPTH)
    ) u_post (
        .clk_in        (SYS_CLK_IN),
        .rst_in        (RST_IN),
        .in_valid_in   (beat_write),
        .in_ready_out  (fifo_ready),
        .in_data_in    ({acc_addr, DATA_LANE_IO_IN, wr_mask}),
        .out_valid_out (drain_valid),
        .out_ready_in  (drain_ready),
        .out_data_out  (drain_data)
    );

    always_ff @(posedge SYS_CLK_IN)
    begin
        if (RST_IN)
        begin
            state     <= sbs_pkg::SBS_ST_DESEL;
            base_hi   <= '0;
            start_low <= '0;
            cnt       <= sbs_pkg::SBS_BURST_FIRST;
            drive     <= 1'b0;
        end
        else
        begin
            state <= next_state;
            if (begin_cycle)
            begin
                base_hi   <= ADDR_IN[ADDR_W-1:BW];
                start_low <= ADDR_IN[BW-1:0];
                cnt       <= sbs_pkg::SBS_BURST_FIRST;
            end
            else if (cont_cycle)
                cnt <= next_cnt;
            case (next_state)
                sbs_pkg::SBS_ST_READ:  drive <= 1'b1;
                sbs_pkg::SBS_ST_WRITE: drive <= 1'b0;
                sbs_pkg::SBS_ST_DESEL: drive <= 1'b0;
                default:               drive <= 1'b0;
            endcase
        end
    end

    // Flow-through read: word appears after the edge that took the address
    always_ff @(posedge SYS_CLK_IN)
    begin
        if (RST_IN)
            dout <= '0;
        else if (beat_read)
            dout <= mem[acc_addr];
    end

    // Lanes with a clear mask bit keep their stored contents
    always_ff @(posedge SYS_CLK_IN)
    begin
        if (drain_valid & drain_ready)
        begin
            for (int i = 0; i < LANES; i++)
            begin
                if (drain_mask[i])
                    mem[drain_addr][i*LANE_W +: LANE_W]
                        <= drain_word[i*LANE_W +: LANE_W];
            end
        end
    end

    a_expand_hi_gate: assert property (
        @(posedge SYS_CLK_IN) disable iff (RST_IN)
        (new_cycle & ~CHIP_ENABLE_EXPAND_HI_IN)
        |=> (state == sbs_pkg::SBS_ST_DESEL) && DATA_LANE_IO_OE_N_OUT)
        else $error("expansion enable low did not deselect");

    a_expand_lo_gate: assert property (
        @(posedge SYS_CLK_IN) disable iff (RST_IN)
        (new_cycle & CHIP_ENABLE_EXPAND_N_IN)
        |=> (state == sbs_pkg::SBS_ST_DESEL) && !drive)
        else $error("expansion enable high did not deselect");

    a_global_all_lanes: assert property (
        @(posedge SYS_CLK_IN) disable iff (RST_IN)
        (beat_write & ~GLOBAL_WRITE_N_IN) |-> (wr_mask == {LANES{1'b1}}))
        else $error("global write did not select every lane");

    a_byte_lane_mask: assert property (
        @(posedge SYS_CLK_IN) disable iff (RST_IN)
        (beat_write & GLOBAL_WRITE_N_IN)
        |-> (wr_mask == ~BYTE_WRITE_SEL_N_IN) && !WRITE_ENABLE_N_IN)
        else $error("byte write mask does not follow selects");

    a_read_decode: assert property (
        @(posedge SYS_CLK_IN) disable iff (RST_IN)
        (begin_cycle & GLOBAL_WRITE_N_IN
         & (WRITE_ENABLE_N_IN | (&BYTE_WRITE_SEL_N_IN)))
        |=> (state == sbs_pkg::SBS_ST_READ) && drive)
        else $error("cycle without write decode was not a read");

    a_oe_float: assert property (
        @(posedge SYS_CLK_IN) disable iff (RST_IN)
        (OUTPUT_ENABLE_N_IN || !drive) |-> DATA_LANE_IO_OE_N_OUT)
        else $error("data bus driven with output enable high");

    a_proc_read: assert property (
        @(posedge SYS_CLK_IN) disable iff (RST_IN)
        (begin_cycle & proc_strobe)
        |=> (state == sbs_pkg::SBS_ST_READ) && drive
            && (cnt == sbs_pkg::SBS_BURST_FIRST))
        else $error("processor strobe did not begin a read");

    a_burst_step: assert property (
        @(posedge SYS_CLK_IN) disable iff (RST_IN)
        (cont_cycle & ~BURST_ADVANCE_N_IN)
        |=> (cnt == BW'($past(cnt) + sbs_pkg::SBS_BURST_STEP)))
        else $error("burst counter did not advance");

    a_burst_hold: assert property (
        @(posedge SYS_CLK_IN) disable iff (RST_IN)
        (cont_cycle & BURST_ADVANCE_N_IN) |=> $stable(cnt))
        else $error("burst counter moved while suspended");

    a_linear_order: assert property (
        @(posedge SYS_CLK_IN) disable iff (RST_IN)
        (cont_cycle & ~BURST_ORDER_SELECT_IN)
        |-> (acc_addr[1:0] == BW'(start_low + next_cnt)))
        else $error("linear burst address wrong");

    a_interleave_order: assert property (
        @(posedge SYS_CLK_IN) disable iff (RST_IN)
        (cont_cycle & BURST_ORDER_SELECT_IN)
        |-> (acc_addr[1:0] == (start_low ^ next_cnt)))
        else $error("interleaved burst address wrong");

    a_proc_ignored: assert property (
        @(posedge SYS_CLK_IN) disable iff (RST_IN)
        (~ADDR_STROBE_PROCESSOR_N_IN & CHIP_ENABLE_PRIMARY_N_IN
         & ADDR_STROBE_CONTROLLER_N_IN
         & (state != sbs_pkg::SBS_ST_DESEL))
        |=> (state != sbs_pkg::SBS_ST_DESEL))
        else $error("ignored processor strobe deselected");

    a_write_float: assert property (
        @(posedge SYS_CLK_IN) disable iff (RST_IN)
        beat_write |=> DATA_LANE_IO_OE_N_OUT
                       && (state == sbs_pkg::SBS_ST_WRITE))
        else $error("data bus driven during a write beat");

    a_proc_deselect: assert property (
        @(posedge SYS_CLK_IN) disable iff (RST_IN)
        (proc_strobe & CHIP_ENABLE_EXPAND_N_IN)
        |=> (state == sbs_pkg::SBS_ST_DESEL) && !drive)
        else $error("processor strobe with enable off did not deselect");

    a_ctrl_deselect: assert property (
        @(posedge SYS_CLK_IN) disable iff (RST_IN)
        (~ADDR_STROBE_CONTROLLER_N_IN & CHIP_ENABLE_PRIMARY_N_IN)
        |=> (state == sbs_pkg::SBS_ST_DESEL) && DATA_LANE_IO_OE_N_OUT)
        else $error("controller strobe with primary enable off kept select");

    a_ctrl_write: assert property (
        @(posedge SYS_CLK_IN) disable iff (RST_IN)
        (begin_cycle & ~proc_strobe & wr_decode)
        |=> (state == sbs_pkg::SBS_ST_WRITE) && !drive)
        else $error("controller strobe with write decode did not write");

    a_begin_address: assert property (
        @(posedge SYS_CLK_IN) disable iff (RST_IN)
        begin_cycle |=> ({base_hi, start_low} == $past(ADDR_IN))
                        && (cnt == sbs_pkg::SBS_BURST_FIRST))
        else $error("new access did not take the external address");
endmodule // sbs_control
`default_nettype wire

// file: sbs_host_model.sv
// Host-side model of the shared data lanes with a contention monitor
`timescale 1ns/1ps
`default_nettype none
module sbs_host_model #(
    parameter int W = 36
) (
    input  wire logic         clk_in,
    input  wire logic         host_drive_in,
    input  wire logic [W-1:0] host_data_in,
    input  wire logic         dev_oe_n_in,
    input  wire logic [W-1:0] dev_data_in,
    output logic      [W-1:0] bus_out,
    output logic              clash_out
);
    logic [W-1:0] last  = '0;
    logic         clash = 1'b0;

    assign clash_out = clash;

    // No keeper on the lanes, so a released bus shows a moving pattern
    assign bus_out = !dev_oe_n_in ? dev_data_in
                   : host_drive_in ? host_data_in : ~last;

    always @(posedge clk_in)
    begin
        last <= bus_out;
        // Both sides driving means the turnaround was broken
        if (!dev_oe_n_in && host_drive_in)
            clash <= 1'b1;
    end
endmodule // sbs_host_model
`default_nettype wire

// file: testbench.sv
// Self-checking bench for the burst SRAM control block
`timescale 1ns/1ps
`default_nettype none
module testbench;
    localparam logic [16:0] A0 = 17'h00100;
    localparam logic [16:0] A1 = 17'h00200;
    localparam logic [16:0] B  = 17'h00040;
    localparam logic [16:0] C  = 17'h00080;
    localparam logic        H  = 1'b1;
    localparam logic        L  = 1'b0;
    logic        clk  = 1'b0;
    logic        rst  = 1'b1;
    logic [2:0]  en   = 3'b110;
    logic        ps   = 1'b1;
    logic        cs   = 1'b1;
    logic        burst_advance_n  = 1'b1;
    logic        ord  = 1'b0;
    logic        gw   = 1'b1;
    logic        we   = 1'b1;
    logic [3:0]  sel  = 4'hf;
    logic [16:0] addr = 17'h0;
    logic        oe   = 1'b1;
    logic        hdrv = 1'b0;
    logic [35:0] hd   = 36'h0;
    wire  [35:0] bus;
    wire  [35:0] dq;
    wire         oe_n;
    wire         rdy;
    wire         clash;
    int          failures = 0;
    int          total_checks = 0;

    sbs_control sbs_control_inst (
        .SYS_CLK_IN(clk), .RST_IN(rst),
        .CHIP_ENABLE_PRIMARY_N_IN(en[2]), .CHIP_ENABLE_EXPAND_HI_IN(en[1]),
        .CHIP_ENABLE_EXPAND_N_IN(en[0]), .ADDR_STROBE_PROCESSOR_N_IN(ps),
        .ADDR_STROBE_CONTROLLER_N_IN(cs), .BURST_ADVANCE_N_IN(burst_advance_n),
        .BURST_ORDER_SELECT_IN(ord), .GLOBAL_WRITE_N_IN(gw),
        .WRITE_ENABLE_N_IN(we), .BYTE_WRITE_SEL_N_IN(sel),
        .ADDR_IN(addr), .OUTPUT_ENABLE_N_IN(oe),
        .DATA_LANE_IO_IN(bus), .DATA_LANE_IO_OUT(dq),
        .DATA_LANE_IO_OE_N_OUT(oe_n), .WRITE_READY_OUT(rdy));

    sbs_host_model sbs_host_model_inst (
        .clk_in(clk), .host_drive_in(hdrv), .host_data_in(hd),
        .dev_oe_n_in(oe_n), .dev_data_in(dq), .bus_out(bus),
        .clash_out(clash));

    initial
    begin
        forever #50 clk = ~clk;
    end

    task automatic results();
        if (failures == 0 && total_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic chk_d(input logic [35:0] got, exp);
        total_checks++;
        if (got !== exp)
        begin
            failures++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_b(input logic got, exp);
        total_checks++;
        if (got !== exp)
        begin
            failures++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    function automatic logic [35:0] wd(input logic [3:0] k);
        return {4{5'h0d, k}};
    endfunction

    // Drives one beat at a rising edge; it is taken at the next one
    task automatic cyc(input logic [2:0] e, input logic s, c, v, g, w,
                       input logic [3:0] b, input logic [16:0] a,
                       input logic [35:0] d, input logic o, h);
        @(posedge clk);
        en <= e;
        ps <= s;
        cs <= c;
        burst_advance_n <= v;
        gw <= g;
        we <= w;
        sel <= b;
        addr <= a;
        hd <= d;
        oe <= o;
        hdrv <= h;
        @(negedge clk);
    endtask

    task automatic wr(input logic [16:0] a, input logic g, w,
                      input logic [3:0] b, input logic [35:0] d,
                      input logic o);
        cyc(3'b010, H, L, H, g, w, b, a, d, o, H);
    endtask

    task automatic rd(input logic [16:0] a);
        cyc(3'b010, H, L, H, H, H, 4'hf, a, 36'h0, L, L);
    endtask

    task automatic ds();
        cyc(3'b110, H, L, H, H, H, 4'hf, 17'h0, 36'h0, L, L);
    endtask

    task automatic go(input logic v);
        cyc(3'b010, H, H, v, H, H, 4'hf, 17'h0, 36'h0, L, L);
    endtask

    task automatic t_global();
        wr(A0, L, H, 4'hf, wd(4'h1), H);
        wr(A0, H, H, 4'h0, wd(4'h2), H);
        repeat (3) ds();
        rd(A0);
        ds();
        chk_d(dq, wd(4'h1));
        chk_b(oe_n, L);
    endtask

    task automatic t_bytes();
        logic [35:0] exp;
        exp = 36'h0;
        wr(A1, L, H, 4'hf, 36'h0, H);
        for (int i = 0; i < 4; i++)
        begin
            wr(A1, H, L, ~(4'h1 << i), wd(4'(i + 4)), H);
            exp[9*i +: 9] = {5'h0d, 4'(i + 4)};
        end
        wr(A1, H, L, 4'hf, 36'hf_ffff_ffff, H);
        repeat (6) ds();
        rd(A1);
        ds();
        chk_d(dq, exp);
    endtask

    task automatic t_burst(input logic o, input logic [1:0] s);
        logic [1:0] cnt [6] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h3, 2'h0};
        logic [1:0] k;
        @(posedge clk);
        ord <= o;
        rd({B[16:2], s});
        for (int j = 0; j < 6; j++)
        begin
            if (j < 5)
                go(j == 3);
            else
                ds();
            k = o ? (s ^ cnt[j]) : (s + cnt[j]);
            chk_d(dq, wd({2'h0, k}));
        end
    endtask

    // The first two entries each fail one enable term and the last fails both expansion terms while a strobe starts an access
    task automatic t_desel();
        logic [2:0] bad [3] = '{3'b000, 3'b011, 3'b001};
        for (int i = 0; i < 3; i++)
        begin
            rd(A0);
            cyc(bad[i], i != 2, i == 2, H, H, H, 4'hf, A0, 36'h0, L, L);
            chk_b(oe_n, L);
            go(L);
            chk_b(oe_n, H);
        end
    endtask

    task automatic t_proc();
        cyc(3'b010, L, H, H, L, H, 4'h0, B, wd(4'h9), L, L);
        cyc(3'b110, L, H, L, H, H, 4'hf, A0, 36'h0, L, L);
        chk_d(dq, wd(4'h0));
        ds();
        chk_d(dq, wd(4'h1));
        chk_b(oe_n, L);
        repeat (2) ds();
        rd(B);
        ds();
        chk_d(dq, wd(4'h0));
    endtask

    task automatic t_oe();
        rd(A0);
        go(H);
        chk_b(oe_n, L);
        cyc(3'b010, H, H, H, H, H, 4'hf, A0, 36'h0, H, L);
        chk_b(oe_n, H);
        go(H);
        chk_b(oe_n, L);
        repeat (2) ds();
        wr(A0, L, H, 4'hf, wd(4'h1), L);
        ds();
        chk_b(oe_n, H);
    endtask

    // Write burst read back; the suspended beat rewrites its own word
    task automatic t_wburst();
        wr(C, L, H, 4'hf, wd(4'ha), H);
        cyc(3'b010, H, H, L, L, H, 4'hf, 17'h0, wd(4'hb), H, H);
        cyc(3'b010, H, H, L, L, H, 4'hf, 17'h0, wd(4'hc), H, H);
        cyc(3'b010, H, H, H, L, H, 4'hf, 17'h0, wd(4'hd), H, H);
        chk_b(oe_n, H);
        repeat (2) ds();
        rd(C);
        go(L);
        chk_d(dq, wd(4'ha));
        go(L);
        chk_d(dq, wd(4'hb));
        ds();
        chk_d(dq, wd(4'hd));
    endtask

    // Cuts a hang short; the scenarios need about a hundred cycles
    initial
    begin
        repeat (3000) @(posedge clk);
        failures++;
        results();
    end

    initial
    begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        chk_b(oe_n, H);
        chk_d(dq, 36'h0);
        chk_b(rdy, H);
        t_global();
        t_bytes();
        for (int k = 0; k < 4; k++)
            wr({B[16:2], 2'(k)}, L, H, 4'hf, wd(4'(k)), H);
        repeat (5) ds();
        t_burst(L, 2'h2);
        t_burst(H, 2'h1);
        t_burst(H, 2'h3);
        t_desel();
        t_proc();
        t_oe();
        t_wburst();
        chk_b(rdy, H);
        chk_b(clash, L);
        results();
    end
endmodule // testbench
`default_nettype wire
